// ===== common/dtc_consts.svh
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// Register byte addresses
`define DTC_ADDR_TCTL 8'h88
`define DTC_ADDR_TIMER_MODE_CONTROL 8'h89
`define DTC_ADDR_TL0 8'h8A
`define DTC_ADDR_TL1 8'h8B
`define DTC_ADDR_TH0 8'h8C
`define DTC_ADDR_TH1 8'h8D
`define DTC_ADDR_CKDIV 8'h8E

// Timer control field positions
`define DTC_TF1_BIT 7
`define DTC_TR1_BIT 6
`define DTC_TF0_BIT 5
`define DTC_TR0_BIT 4
`define DTC_IE1_BIT 3
`define DTC_IT1_BIT 2
`define DTC_IE0_BIT 1
`define DTC_IT0_BIT 0

// Clock divider control field positions
`define DTC_T1M_BIT 4
`define DTC_T0M_BIT 3

// Reset values
`define DTC_RST_BYTE 8'h00

// Machine tick divider: counts 0..11, fast tick every fourth count
`define DTC_DIV_LAST 4'hB
`define DTC_DIV_FAST 2'h3

// Pin index in the synchroniser vector
`define DTC_PIN_CNT0 0
`define DTC_PIN_CNT1 1
`define DTC_PIN_IRQ0 2
`define DTC_PIN_IRQ1 3

`endif

// ===== common/dtc_pkg.sv
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE = 2'h0,
        DTC_MODE_FULL16 = 2'h1,
        DTC_MODE_RELOAD8 = 2'h2,
        DTC_MODE_SPLIT = 2'h3
    } dtc_mode_t;

    // One timer nibble of the mode register
    typedef struct packed {
        logic gate;
        logic cnt_sel;
        dtc_mode_t mode;
    } dtc_timer_mode_control_t;

    // Result of one counting step
    typedef struct packed {
        logic [7:0] th;
        logic [7:0] tl;
        logic ovf;
    } dtc_step_t;

endpackage

// ===== core/dtc_pin_sync.sv
`timescale 1ns/1ps
`include "dtc_consts.svh"

module dtc_pin_sync
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Raw pins
    input wire logic [3:0] i_pins,
    // Filtered level and falling-edge pulse
    output logic [3:0] o_level,
    output logic [3:0] o_fall
);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            logic fall_q;
            logic agree;

            // Level is accepted once the second and third stages agree
            assign agree = (s2_q == s3_q);

            // Pins idle high, so reset to high avoids a false edge
            always_ff @(posedge i_clk_sys or negedge i_resetn) begin
                if (!i_resetn) begin
                    s1_q <= 1'b1;
                    s2_q <= 1'b1;
                    s3_q <= 1'b1;
                    lvl_q <= 1'b1;
                    fall_q <= 1'b0;
                end else begin
                    s1_q <= i_pins[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (agree) begin
                        lvl_q <= s3_q;
                    end
                    fall_q <= agree & lvl_q & ~s3_q;
                end
            end

            assign o_level[gi] = lvl_q;
            assign o_fall[gi] = fall_q;
        end
    endgenerate

endmodule

// ===== core/dtc_timer_top.sv
`timescale 1ns/1ps
`include "dtc_consts.svh"

// Functional notes
// - Timer one flag: set, vector clear, software
// - Timer zero flag: set, vector clear, software
// - Run bits six and four stop timers
// - External flags: edge clears on vector, level tracks
// - Type bit picks falling edge or low level
// - Gate needs run bit and high pin
// - Select bit picks clock or pin falls
// - Mode zero: eight bits, five-bit prescale
// - Mode one: sixteen-bit count
// - Mode two: low byte reloads from high
// - Mode three splits timer zero, stops one
// - Timer one tick divides by 4 or 12
// - Timer zero tick divides by 4 or 12
module dtc_timer_top
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Pins
    input wire logic i_cnt_pin_zero,
    input wire logic i_cnt_pin_one,
    input wire logic i_ext_irq_pin_zero,
    input wire logic i_ext_irq_pin_one,
    // Interrupt vector acknowledges
    input wire logic i_vec_timer_zero,
    input wire logic i_vec_timer_one,
    input wire logic i_vec_ext_zero,
    input wire logic i_vec_ext_one,
    // Flags to the interrupt controller
    output logic o_timer_zero_overflow_flag,
    output logic o_timer_one_overflow_flag,
    output logic o_ext_irq_zero_flag,
    output logic o_ext_irq_one_flag
);

    // One counting step in a given mode
    function automatic dtc_step_t dtc_step(input dtc_mode_t mode, input logic [7:0] th,
                                           input logic [7:0] tl, input logic inc);
        dtc_step_t r;
        logic [12:0] c13;
        r = '{th: th, tl: tl, ovf: 1'b0};
        c13 = {th, tl[4:0]};
        if (inc) begin
            case (mode)
                DTC_MODE_PRESCALE: begin
                    r.ovf = &c13;
                    c13 = c13 + 13'h0001;
                    r.th = c13[12:5];
                    r.tl = {tl[7:5], c13[4:0]};
                end
                DTC_MODE_FULL16: begin
                    r.ovf = &{th, tl};
                    {r.th, r.tl} = {th, tl} + 16'h0001;
                end
                DTC_MODE_RELOAD8: begin
                    r.ovf = &tl;
                    r.tl = (&tl) ? th : tl + 8'h01;
                end
                default: begin
                    r.ovf = &tl;
                    r.tl = tl + 8'h01;
                end
            endcase
        end
        return r;
    endfunction

    // Registers
    logic [7:0] tctl_q;
    logic [7:0] tctl_d;
    logic [7:0] timer_mode_control_q;
    logic [7:0] ckdiv_q;
    logic [7:0] tl0_q;
    logic [7:0] tl0_d;
    logic [7:0] th0_q;
    logic [7:0] th0_d;
    logic [7:0] tl1_q;
    logic [7:0] tl1_d;
    logic [7:0] th1_q;
    logic [7:0] th1_d;
    logic [3:0] div_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [3:0] lvl;
    logic [3:0] fall;

    dtc_pin_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_pins({i_ext_irq_pin_one, i_ext_irq_pin_zero, i_cnt_pin_one, i_cnt_pin_zero}),
        .o_level(lvl),
        .o_fall(fall)
    );

    // Address decode
    wire wr_tctl = i_wr && (i_addr == `DTC_ADDR_TCTL);
    wire wr_timer_mode_control = i_wr && (i_addr == `DTC_ADDR_TIMER_MODE_CONTROL);
    wire wr_ckdiv = i_wr && (i_addr == `DTC_ADDR_CKDIV);
    wire wr_tl0 = i_wr && (i_addr == `DTC_ADDR_TL0);
    wire wr_th0 = i_wr && (i_addr == `DTC_ADDR_TH0);
    wire wr_tl1 = i_wr && (i_addr == `DTC_ADDR_TL1);
    wire wr_th1 = i_wr && (i_addr == `DTC_ADDR_TH1);

    // Field views
    dtc_timer_mode_control_t cfg0;
    dtc_timer_mode_control_t cfg1;
    assign cfg0 = timer_mode_control_q[3:0];
    assign cfg1 = timer_mode_control_q[7:4];
    wire tr0 = tctl_q[`DTC_TR0_BIT];
    wire tr1 = tctl_q[`DTC_TR1_BIT];
    wire it0 = tctl_q[`DTC_IT0_BIT];
    wire it1 = tctl_q[`DTC_IT1_BIT];
    wire split = (cfg0.mode == DTC_MODE_SPLIT);

    // Shared divider gives both tick rates from one counter
    wire tick_fast = (div_q[1:0] == `DTC_DIV_FAST);
    wire tick_slow = (div_q == `DTC_DIV_LAST);
    wire clk0 = ckdiv_q[`DTC_T0M_BIT] ? tick_fast : tick_slow;
    wire clk1 = ckdiv_q[`DTC_T1M_BIT] ? tick_fast : tick_slow;

    // internal tick or pin falling edge
    wire src0 = cfg0.cnt_sel ? fall[`DTC_PIN_CNT0] : clk0;
    wire src1 = cfg1.cnt_sel ? fall[`DTC_PIN_CNT1] : clk1;
    wire gok0 = ~cfg0.gate | lvl[`DTC_PIN_IRQ0];
    wire gok1 = ~cfg1.gate | lvl[`DTC_PIN_IRQ1];
    wire en0 = tr0 & gok0 & src0;
    // timer one holds while timer zero is split
    // Its own mode three stops it too, so the split high byte owns the flag alone
    wire en1 = tr1 & gok1 & src1 & ~split & (cfg1.mode != DTC_MODE_SPLIT);
    wire en_h0 = split & tr1 & clk1;

    // mode steps; handled in the step function, except the split high byte
    dtc_step_t st0;
    dtc_step_t st1;
    assign st0 = dtc_step(cfg0.mode, th0_q, tl0_q, en0);
    assign st1 = dtc_step(cfg1.mode, th1_q, tl1_q, en1);
    wire ovf_h0 = en_h0 & (&th0_q);
    wire ovf0 = st0.ovf;
    wire ovf1 = st1.ovf | ovf_h0;

    // Software writes to a count byte win over the increment
    assign tl0_d = wr_tl0 ? i_wdata : st0.tl;
    assign th0_d = wr_th0 ? i_wdata : (split ? th0_q + {7'h00, en_h0} : st0.th);
    assign tl1_d = wr_tl1 ? i_wdata : st1.tl;
    assign th1_d = wr_th1 ? i_wdata : st1.th;

    // Flag updates: a hardware set beats both vector and software clear
    always_comb begin
        tctl_d = wr_tctl ? i_wdata : tctl_q;
        tctl_d[`DTC_TF1_BIT] = ovf1 | (~i_vec_timer_one & tctl_d[`DTC_TF1_BIT]);
        tctl_d[`DTC_TF0_BIT] = ovf0 | (~i_vec_timer_zero & tctl_d[`DTC_TF0_BIT]);
        // edge flags clear on vector, level flags follow pin
        tctl_d[`DTC_IE0_BIT] = fall[`DTC_PIN_IRQ0] | (~i_vec_ext_zero & tctl_d[`DTC_IE0_BIT]);
        tctl_d[`DTC_IE1_BIT] = fall[`DTC_PIN_IRQ1] | (~i_vec_ext_one & tctl_d[`DTC_IE1_BIT]);
        if (!tctl_d[`DTC_IT0_BIT]) begin
            tctl_d[`DTC_IE0_BIT] = ~lvl[`DTC_PIN_IRQ0];
        end
        if (!tctl_d[`DTC_IT1_BIT]) begin
            tctl_d[`DTC_IE1_BIT] = ~lvl[`DTC_PIN_IRQ1];
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (i_addr)
            `DTC_ADDR_TCTL: rdata_d = tctl_q;
            `DTC_ADDR_TIMER_MODE_CONTROL: rdata_d = timer_mode_control_q;
            `DTC_ADDR_TL0: rdata_d = tl0_q;
            `DTC_ADDR_TL1: rdata_d = tl1_q;
            `DTC_ADDR_TH0: rdata_d = th0_q;
            `DTC_ADDR_TH1: rdata_d = th1_q;
            `DTC_ADDR_CKDIV: rdata_d = ckdiv_q;
            default: rdata_d = `DTC_RST_BYTE;
        endcase
        if (!i_rd) begin
            rdata_d = `DTC_RST_BYTE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            tctl_q <= `DTC_RST_BYTE;
            timer_mode_control_q <= `DTC_RST_BYTE;
            ckdiv_q <= `DTC_RST_BYTE;
            tl0_q <= `DTC_RST_BYTE;
            th0_q <= `DTC_RST_BYTE;
            tl1_q <= `DTC_RST_BYTE;
            th1_q <= `DTC_RST_BYTE;
            div_q <= 4'h0;
            rdata_q <= `DTC_RST_BYTE;
        end else begin
            tctl_q <= tctl_d;
            timer_mode_control_q <= wr_timer_mode_control ? i_wdata : timer_mode_control_q;
            ckdiv_q <= wr_ckdiv ? i_wdata : ckdiv_q;
            tl0_q <= tl0_d;
            th0_q <= th0_d;
            tl1_q <= tl1_d;
            th1_q <= th1_d;
            div_q <= tick_slow ? 4'h0 : div_q + 4'h1;
            rdata_q <= rdata_d;
        end
    end

    // Outputs straight from registers
    assign o_rdata = rdata_q;
    assign o_timer_zero_overflow_flag = tctl_q[`DTC_TF0_BIT];
    assign o_timer_one_overflow_flag = tctl_q[`DTC_TF1_BIT];
    assign o_ext_irq_zero_flag = tctl_q[`DTC_IE0_BIT];
    assign o_ext_irq_one_flag = tctl_q[`DTC_IE1_BIT];

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence slow_gap_s;
        (!tick_slow) [*8] ##1 (!tick_slow) [*3] ##1 tick_slow;
    endsequence

    sequence fast_gap_s;
        (!tick_fast) [*3] ##1 tick_fast;
    endsequence

    tf0_set_a: assert property (ovf0 |=> tctl_q[`DTC_TF0_BIT])
        else $error("timer zero flag not set on overflow");
    tf1_set_a: assert property (ovf1 |=> o_timer_one_overflow_flag)
        else $error("timer one flag not set on overflow");
    run_stop_a: assert property (!tr0 && !split && !wr_tl0 && !wr_th0 |=>
                                 $stable(tl0_q) && $stable(th0_q))
        else $error("stopped timer zero moved");
    level_track_a: assert property (!it0 && !wr_tctl |=>
                                    tctl_q[`DTC_IE0_BIT] == !$past(lvl[`DTC_PIN_IRQ0]))
        else $error("level flag does not follow pin");
    edge_clear_a: assert property (it0 && !wr_tctl && i_vec_ext_zero
                                   && !fall[`DTC_PIN_IRQ0] |=> !tctl_q[`DTC_IE0_BIT])
        else $error("edge flag not cleared by vector");
    gate_hold_a: assert property (cfg0.gate && !lvl[`DTC_PIN_IRQ0] && !wr_tl0
                                  && !wr_timer_mode_control |=> $stable(tl0_q))
        else $error("gated timer zero advanced");
    reload_a: assert property (cfg0.mode == DTC_MODE_RELOAD8 && en0 && tl0_q == 8'hFF
                               && !wr_tl0 |=> tl0_q == $past(th0_q))
        else $error("auto reload missing");
    carry16_a: assert property (cfg0.mode == DTC_MODE_FULL16 && en0 && tl0_q == 8'hFF
                                && !wr_th0 && !wr_tl0 |=> th0_q == $past(th0_q) + 8'h01)
        else $error("sixteen-bit carry missing");
    split_hold_a: assert property ((split || cfg1.mode == DTC_MODE_SPLIT)
                                   && !wr_tl1 && !wr_th1 |=> $stable(tl1_q) && $stable(th1_q))
        else $error("timer one moved in split mode");
    slow_tick_a: assert property (tick_slow |=> slow_gap_s)
        else $error("slow tick period wrong");
    fall_pulse_a: assert property (fall[`DTC_PIN_CNT0] |=> !fall[`DTC_PIN_CNT0])
        else $error("edge pulse longer than one cycle");

    // Tick spacing and divider range
    fast_tick_a: assert property (tick_fast |=> fast_gap_s)
        else $error("fast tick period wrong");
    div_range_a: assert property (div_q <= `DTC_DIV_LAST)
        else $error("divider left its range");

    // Vector acknowledges clear flags unless a set lands in the same cycle
    vec_clear_zero_a: assert property (i_vec_timer_zero && !ovf0 && !wr_tctl
                                       |=> !o_timer_zero_overflow_flag)
        else $error("timer zero flag not cleared by vector");
    vec_clear_one_a: assert property (i_vec_timer_one && !ovf1 && !wr_tctl
                                      |=> !o_timer_one_overflow_flag)
        else $error("timer one flag not cleared by vector");
    edge_clear_one_a: assert property (it1 && !wr_tctl && i_vec_ext_one
                                       && !fall[`DTC_PIN_IRQ1] |=> !o_ext_irq_one_flag)
        else $error("edge flag one not cleared by vector");

    // Counter mode moves only on a pin fall; split high byte follows timer one ticks
    pin_only_a: assert property (cfg0.cnt_sel && !fall[`DTC_PIN_CNT0] && !wr_tl0
                                 |=> $stable(tl0_q))
        else $error("counter moved without a pin fall");
    split_count_a: assert property (en_h0 && !wr_th0
                                    |=> th0_q == $past(th0_q) + 8'h01)
        else $error("split high byte did not count");

endmodule

// ===== tb/dtc_pin_model.sv
`timescale 1ns/1ps

module dtc_pin_model (
    // Clock
    input wire logic i_clk_sys,
    // Pin levels, idle high
    output logic [3:0] o_pins
);
    // Pins idle high, so the synchroniser sees no edge at start
    initial o_pins = 4'hF;

    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge i_clk_sys);
            o_pins[idx] <= 1'b0;
            repeat (4) @(posedge i_clk_sys);
            o_pins[idx] <= 1'b1;
            repeat (4) @(posedge i_clk_sys);
        end
    endtask

    // Static level, held long enough to pass the synchroniser
    task automatic level(input int idx, input logic lvl);
        @(posedge i_clk_sys);
        o_pins[idx] <= lvl;
        repeat (6) @(posedge i_clk_sys);
    endtask
endmodule

// ===== tb/dtc_timer_top_tb_top.sv
`timescale 1ns/1ps
`include "dtc_consts.svh"

module dtc_timer_top_tb_top
    import dtc_pkg::*;
;
    logic i_clk_sys;
    logic i_resetn;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    logic [3:0] vec;
    wire [3:0] fl;
    wire [3:0] pins;
    int miscompares;
    int n_tests;
    int n;

    dtc_timer_top u_dtc_timer_top (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_cnt_pin_zero(pins[`DTC_PIN_CNT0]),
        .i_cnt_pin_one(pins[`DTC_PIN_CNT1]),
        .i_ext_irq_pin_zero(pins[`DTC_PIN_IRQ0]),
        .i_ext_irq_pin_one(pins[`DTC_PIN_IRQ1]),
        .i_vec_timer_zero(vec[0]),
        .i_vec_timer_one(vec[1]),
        .i_vec_ext_zero(vec[2]),
        .i_vec_ext_one(vec[3]),
        .o_timer_zero_overflow_flag(fl[0]),
        .o_timer_one_overflow_flag(fl[1]),
        .o_ext_irq_zero_flag(fl[2]),
        .o_ext_irq_one_flag(fl[3])
    );

    dtc_pin_model u_dtc_pin_model (
        .i_clk_sys(i_clk_sys),
        .o_pins(pins)
    );

    // 100 MHz system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask

    task automatic fc(input int idx, input logic e);
        #1 chk({7'h00, fl[idx]}, {7'h00, e});
    endtask

    task automatic vpulse(input int idx);
        @(posedge i_clk_sys);
        vec[idx] <= 1'b1;
        @(posedge i_clk_sys);
        vec[idx] <= 1'b0;
    endtask

    // Bounded wait for a flag, n counts the cycles taken
    task automatic waitf(input int idx);
        n = 0;
        while (fl[idx] !== 1'b1) begin
            if (n == 600) begin
                miscompares++;
                finish_test();
            end
            @(posedge i_clk_sys);
            #1 n++;
        end
    endtask

    // Main sequence
    initial begin
        i_resetn = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        vec = 4'h0;
        n_tests = 0;
        miscompares = 0;
        repeat (2) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        for (int a = 8'h88; a <= 8'h8E; a++) rdc(8'(a), 8'h00);
        rdc(8'h80, 8'h00);
        wr(`DTC_ADDR_TL1, 8'hA5);
        rdc(`DTC_ADDR_TL1, 8'hA5);
        $display("test registers done");
        // Timer 0 reload mode, fast tick
        wr(`DTC_ADDR_TIMER_MODE_CONTROL, {4'h0, 2'b00, DTC_MODE_RELOAD8});
        wr(`DTC_ADDR_TH0, 8'hFE);
        wr(`DTC_ADDR_TL0, 8'hFE);
        wr(`DTC_ADDR_CKDIV, 8'h08);
        wr(`DTC_ADDR_TCTL, 8'h10);
        waitf(0);
        chk({7'h00, n <= 11}, 8'h01);
        wr(`DTC_ADDR_TCTL, 8'h20);
        fc(0, 1'b1);
        @(posedge i_clk_sys);
        i_addr <= `DTC_ADDR_TL0;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk({1'b0, o_rdata[7:1]}, 8'h7F);
        repeat (40) @(posedge i_clk_sys);
        rdc(`DTC_ADDR_TL0, 8'hFE);
        vpulse(0);
        fc(0, 1'b0);
        wr(`DTC_ADDR_TCTL, 8'h20);
        fc(0, 1'b1);
        $display("test timer zero reload done");
        // Timer 1 sixteen-bit mode, slow tick
        wr(`DTC_ADDR_TIMER_MODE_CONTROL, {2'b00, DTC_MODE_FULL16, 4'h0});
        wr(`DTC_ADDR_TL1, 8'hFE);
        wr(`DTC_ADDR_TH1, 8'hFF);
        wr(`DTC_ADDR_CKDIV, 8'h00);
        wr(`DTC_ADDR_TCTL, 8'h40);
        waitf(1);
        chk({7'h00, n >= 12 && n <= 26}, 8'h01);
        rdc(`DTC_ADDR_TH1, 8'h00);
        vpulse(1);
        fc(1, 1'b0);
        wr(`DTC_ADDR_TCTL, 8'h00);
        $display("test timer one done");
        // Gated pin counter on timer 0
        wr(`DTC_ADDR_TIMER_MODE_CONTROL, {4'h0, 2'b11, DTC_MODE_FULL16});
        // Start just below the carry so the third fall with the gate open reaches the high byte
        wr(`DTC_ADDR_TL0, 8'hFD);
        wr(`DTC_ADDR_TH0, 8'h00);
        wr(`DTC_ADDR_TCTL, 8'h10);
        u_dtc_pin_model.level(`DTC_PIN_IRQ0, 1'b0);
        fc(2, 1'b1);
        vpulse(2);
        fc(2, 1'b1);
        u_dtc_pin_model.pulse(`DTC_PIN_CNT0, 3);
        rdc(`DTC_ADDR_TL0, 8'hFD);
        u_dtc_pin_model.level(`DTC_PIN_IRQ0, 1'b1);
        fc(2, 1'b0);
        u_dtc_pin_model.pulse(`DTC_PIN_CNT0, 5);
        rdc(`DTC_ADDR_TL0, 8'h02);
        rdc(`DTC_ADDR_TH0, 8'h01);
        $display("test pin counter done");
        // Falling-edge type on both interrupt inputs
        wr(`DTC_ADDR_TCTL, 8'h05);
        u_dtc_pin_model.pulse(`DTC_PIN_IRQ1, 1);
        fc(3, 1'b1);
        vpulse(3);
        fc(3, 1'b0);
        u_dtc_pin_model.pulse(`DTC_PIN_IRQ0, 1);
        fc(2, 1'b1);
        vpulse(2);
        fc(2, 1'b0);
        $display("test edge interrupt done");
        // Split mode: high byte of timer 0 under timer 1 run bit
        wr(`DTC_ADDR_TIMER_MODE_CONTROL, {2'b00, DTC_MODE_FULL16, 2'b00, DTC_MODE_SPLIT});
        wr(`DTC_ADDR_TH0, 8'hFF);
        wr(`DTC_ADDR_TL1, 8'h00);
        wr(`DTC_ADDR_CKDIV, 8'h10);
        wr(`DTC_ADDR_TCTL, 8'h40);
        waitf(1);
        rdc(`DTC_ADDR_TL1, 8'h00);
        rdc(`DTC_ADDR_TL0, 8'h02);
        // Prescaled mode: carry from bit 4 of the low byte
        wr(`DTC_ADDR_TCTL, 8'h00);
        wr(`DTC_ADDR_TIMER_MODE_CONTROL, {4'h0, 2'b00, DTC_MODE_PRESCALE});
        wr(`DTC_ADDR_TH0, 8'h00);
        wr(`DTC_ADDR_TL0, 8'hFF);
        wr(`DTC_ADDR_CKDIV, 8'h08);
        wr(`DTC_ADDR_TCTL, 8'h10);
        repeat (3) @(posedge i_clk_sys);
        wr(`DTC_ADDR_TCTL, 8'h00);
        rdc(`DTC_ADDR_TH0, 8'h01);
        @(posedge i_clk_sys);
        i_addr <= `DTC_ADDR_TL0;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk({1'b0, o_rdata[7:1]}, 8'h70);
        $display("test split and prescale done");
        finish_test();
    end
endmodule
